// [boot_loader_pkg.sv]
/*
  Shared constants and state types for the boot loader and the
  interrupt presenter. Assumes a 10 MHz system clock.
*/
package boot_loader_pkg;

  // ********************************************************
  // Timing
  // ********************************************************
  localparam int CLOCK_NS        = 100;
  localparam int I2C_QUARTER_NS  = 2500;
  localparam int I2C_QUARTER_CYC = (I2C_QUARTER_NS + CLOCK_NS - 1) / CLOCK_NS;

  // ********************************************************
  // Boot memory layout
  // ********************************************************
  localparam logic [7:0]  HDR_MAGIC        = 8'hC4;
  localparam logic [15:0] IDX_HDR          = 16'h0000;
  localparam logic [15:0] IDX_IFCFG        = 16'h0001;
  localparam logic [15:0] IDX_POL          = 16'h0002;
  localparam logic [15:0] IDX_DESC_FLAG    = 16'h0003;
  localparam logic [15:0] IDX_LEN_LO       = 16'h0004;
  localparam logic [15:0] IDX_LEN_HI       = 16'h0005;
  localparam logic [15:0] IDX_PAYLOAD      = 16'h0006;
  localparam logic [15:0] DESC_MAX_LEN     = 16'h01F4;
  localparam logic [15:0] DEFAULT_DESC_LEN = 16'h0006;
  localparam logic [5:0]  MASTER_DESC_REG  = 6'h30;
  localparam logic [3:0]  EEPROM_DEV_BASE  = 4'hA;
  localparam logic [2:0]  STRAP_ONE_BYTE   = 3'h0;
  localparam logic [2:0]  STRAP_TWO_BYTE   = 3'h1;

  // ********************************************************
  // Reset values (identity value is arbitrary)
  // ********************************************************
  localparam logic [7:0]  IFCFG_RESET = 8'h00;
  localparam logic [7:0]  POL_RESET   = 8'h00;
  localparam logic [47:0] ID_RESET    = 48'h0000_0000_0000;

  // ********************************************************
  // Default enumeration endpoints (ep2, ep4, ep6, ep8)
  // ********************************************************
  localparam logic [3:0] EP_IN_DEFAULT = 4'hC;
  localparam logic [9:0] PKT_HS        = 10'h200;
  localparam logic [9:0] PKT_FS        = 10'h040;

  // ********************************************************
  // Interrupt status bit positions
  // ********************************************************
  localparam int IRQ_SETUP_BIT      = 7;
  localparam int IRQ_CTRL_BUF_BIT   = 6;
  localparam int IRQ_OUT_FIFO_BIT   = 5;
  localparam int IRQ_ENUM_DONE_BIT  = 2;
  localparam int IRQ_USB_IDLE_BIT   = 1;
  localparam int IRQ_READY_BIT      = 0;

  typedef enum logic [2:0] {
    S_IDLE  = 3'h0,
    S_START = 3'h1,
    S_TX    = 3'h2,
    S_RX    = 3'h3,
    S_STOP  = 3'h4
  } i2c_state_t;

  typedef enum logic [2:0] {
    B_STRAP  = 3'h0,
    B_READ   = 3'h1,
    B_WAIT   = 3'h2,
    B_MASTER = 3'h3,
    B_ENUM   = 3'h4
  } boot_state_t;

endpackage : boot_loader_pkg

// [eeprom_byte_reader.sv]
/*
  Two-wire random read of one byte from the boot memory.
  Assumes pull-ups on both lines; index and strap stay stable
  from start until done.
*/
`timescale 1ns/1ns
module eeprom_byte_reader (
  input  wire logic        i_clock,
  input  wire logic        i_rstn,
  input  wire logic        i_start,
  input  wire logic        i_two_addr,
  input  wire logic [2:0]  i_strap,
  input  wire logic [15:0] i_index,
  input  wire logic        i_scl_in,
  input  wire logic        i_sda_in,
  output logic             o_scl_oe,
  output logic             o_sda_oe,
  output logic             o_done,
  output logic             o_nack,
  output logic [7:0]       o_data
);

  boot_loader_pkg::i2c_state_t state_ff;
  logic [4:0] div_ff;
  logic [1:0] q_ff;
  logic [3:0] bit_ff;
  logic [2:0] seg_ff;
  logic [7:0] shift_ff;
  logic       nack_ff;

  // Segment 0 control write, 1 index high, 2 index low, 3 control read
  function automatic logic [7:0] tx_sel(input logic [2:0] seg, input logic [15:0] idx,
                                        input logic [2:0] strap);
    unique case (seg)
      3'h0:    tx_sel = {boot_loader_pkg::EEPROM_DEV_BASE, strap, 1'b0};
      3'h1:    tx_sel = idx[15:8];
      3'h2:    tx_sel = idx[7:0];
      default: tx_sel = {boot_loader_pkg::EEPROM_DEV_BASE, strap, 1'b1};
    endcase
  endfunction : tx_sel

  wire       div_end = div_ff == 5'(boot_loader_pkg::I2C_QUARTER_CYC - 1);
  // A slave holding the clock low stalls the bit (clock stretching)
  wire       tick    = div_end & ((q_ff != 2'h2) | i_scl_in);
  wire [4:0] nxt_div = tick ? 5'h00 : (div_end ? div_ff : 5'(div_ff + 5'h01));
  wire [2:0] nxt_seg = (seg_ff == 3'h0) ? (i_two_addr ? 3'h1 : 3'h2) : 3'(seg_ff + 3'h1);
  wire       last    = bit_ff == 4'h8;

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      state_ff <= boot_loader_pkg::S_IDLE;
      div_ff   <= 5'h00;
      q_ff     <= 2'h0;
      bit_ff   <= 4'h0;
      seg_ff   <= 3'h0;
      shift_ff <= 8'h00;
      nack_ff  <= 1'b0;
      o_scl_oe <= 1'b0;
      o_sda_oe <= 1'b0;
      o_done   <= 1'b0;
      o_nack   <= 1'b0;
      o_data   <= 8'h00;
    end else begin
      o_done <= 1'b0;
      div_ff <= nxt_div;
      if (state_ff == boot_loader_pkg::S_IDLE) begin
        q_ff <= 2'h0;
        if (i_start) begin
          state_ff <= boot_loader_pkg::S_START;
          seg_ff   <= 3'h0;
          nack_ff  <= 1'b0;
        end
      end else if (tick) begin
        q_ff <= 2'(q_ff + 2'h1);
        unique case (state_ff)
          boot_loader_pkg::S_START: begin
            unique case (q_ff)
              2'h0: o_sda_oe <= 1'b0;
              2'h1: o_scl_oe <= 1'b0;
              2'h2: o_sda_oe <= 1'b1;
              2'h3: begin
                o_scl_oe <= 1'b1;
                state_ff <= boot_loader_pkg::S_TX;
                bit_ff   <= 4'h0;
                shift_ff <= tx_sel(seg_ff, i_index, i_strap);
              end
            endcase
          end
          boot_loader_pkg::S_TX: begin
            unique case (q_ff)
              2'h0: o_sda_oe <= last ? 1'b0 : ~shift_ff[7];
              2'h1: o_scl_oe <= 1'b0;
              2'h2: if (last) nack_ff <= i_sda_in;
              2'h3: begin
                o_scl_oe <= 1'b1;
                bit_ff   <= 4'(bit_ff + 4'h1);
                shift_ff <= {shift_ff[6:0], 1'b0};
                if (last) begin
                  bit_ff <= 4'h0;
                  seg_ff <= nxt_seg;
                  if (nack_ff) state_ff <= boot_loader_pkg::S_STOP;
                  else if (nxt_seg == 3'h3) state_ff <= boot_loader_pkg::S_START;
                  else if (nxt_seg == 3'h4) state_ff <= boot_loader_pkg::S_RX;
                  else shift_ff <= tx_sel(nxt_seg, i_index, i_strap);
                end
              end
            endcase
          end
          boot_loader_pkg::S_RX: begin
            unique case (q_ff)
              2'h0: o_sda_oe <= 1'b0;
              2'h1: o_scl_oe <= 1'b0;
              2'h2: if (!last) shift_ff <= {shift_ff[6:0], i_sda_in};
              2'h3: begin
                o_scl_oe <= 1'b1;
                bit_ff   <= 4'(bit_ff + 4'h1);
                if (last) state_ff <= boot_loader_pkg::S_STOP;
              end
            endcase
          end
          boot_loader_pkg::S_STOP: begin
            unique case (q_ff)
              2'h0: o_sda_oe <= 1'b1;
              2'h1: o_scl_oe <= 1'b0;
              2'h2: o_sda_oe <= 1'b0;
              2'h3: begin
                state_ff <= boot_loader_pkg::S_IDLE;
                o_done   <= 1'b1;
                o_nack   <= nack_ff;
                o_data   <= shift_ff;
              end
            endcase
          end
          boot_loader_pkg::S_IDLE: q_ff <= 2'h0;
        endcase
      end
    end
  end

endmodule : eeprom_byte_reader

// [usb_boot_loader_and_irq.sv]
/*
  Start-up loader and interrupt presenter of a USB peripheral bridge.
  Probes a boot memory, loads configuration and descriptor or identity
  bytes, else takes them from the external master, then connects.
  Assumes all inputs synchronous to I_CLOCK and event inputs one-cycle pulses.
*/
`timescale 1ns/1ns

// Function
// - Probe the two-wire bus at power-up and boot from a memory that answers.
// - Header byte 0 equal 0xC4 loads bytes 1 and 2 into config and polarity.
// - Byte 3 equal 0xC4 enumerates from the stored descriptor, then enum-done.
// - Byte 3 not 0xC4 skips stored descriptor; wait for the master.
// - No memory: master supplies descriptors; connect only after receiving them.
// - Descriptor length is read from bytes 4 and 5, low byte first.
// - Descriptor starts at byte 6 and may be up to 500 bytes.
// - Length 6 loads vendor, product, release ids and uses built-in descriptor.
// - Default: ep2, ep4 bulk out, ep6, ep8 bulk in; 512 or 64 bytes.
// - Strap 000 uses one index byte, strap 001 uses two.
// - Six interrupt sources, each gated by its enable mask bit.
// - An enabled event asserts the low-active interrupt and sets its status bit.
// - Master strobes read and output enable; status byte goes on data lines.
// - Reading the status byte clears the interrupt it reported.
// - Only one interrupt presented at a time; others stay queued.
// - The interrupt line also announces data for a pending register read.
// - A started register read holds back interrupts until its data is read.
// - Status bits: 7 setup, 6 ctrl buffer, 5 out fifo, 2 enum, 1 idle, 0 ready.
// - Ready interrupt after power-up, or enum-done instead with a valid descriptor.
// - Enum-done is raised on the host's set-configuration request.
module usb_boot_loader_and_irq (
  input  wire logic        I_CLOCK,
  input  wire logic        I_RSTN,
  input  wire logic [2:0]  I_EEPROM_ADDR_STRAP,
  input  wire logic        I_EEPROM_SCL_IN,
  input  wire logic        I_EEPROM_SDA_IN,
  input  wire logic        I_HIGH_SPEED,
  input  wire logic        I_CMD_WRITE,
  input  wire logic [5:0]  I_CMD_ADDR,
  input  wire logic [7:0]  I_CMD_DATA,
  input  wire logic        I_SETUP_EVT,
  input  wire logic        I_CTRL_BUFFER_AVAIL_EVT,
  input  wire logic        I_OUT_FIFO_CHANGE_EVT,
  input  wire logic        I_SET_CONFIG_EVT,
  input  wire logic        I_USB_IDLE_CHANGE_EVT,
  input  wire logic [7:0]  I_IRQ_ENABLE_MASK,
  input  wire logic        I_REG_READ_REQ,
  input  wire logic        I_REG_READ_VALID,
  input  wire logic [7:0]  I_REG_READ_DATA,
  input  wire logic        I_SLAVE_READ_STROBE,
  input  wire logic        I_SLAVE_OUTPUT_ENABLE,
  output logic             O_EEPROM_SCL_OUT,
  output logic             O_EEPROM_SCL_OE,
  output logic             O_EEPROM_SDA_OUT,
  output logic             O_EEPROM_SDA_OE,
  output logic [7:0]       O_INTERFACE_CONFIG,
  output logic [7:0]       O_FLAG_POLARITY,
  output logic [15:0]      O_VENDOR_ID,
  output logic [15:0]      O_PRODUCT_ID,
  output logic [15:0]      O_DEVICE_RELEASE_ID,
  output logic [15:0]      O_DESC_LENGTH,
  output logic [7:0]       O_DESC_BYTE,
  output logic [8:0]       O_DESC_ADDR,
  output logic             O_DESC_WE,
  output logic             O_DEFAULT_DESC,
  output logic [3:0]       O_EP_IN_MASK,
  output logic [9:0]       O_EP_MAX_PKT,
  output logic             O_USB_CONNECT,
  output logic             O_IRQ_N,
  output logic [7:0]       O_HOST_DATA_BUS,
  output logic             O_HOST_DATA_OE
);

  // ********************************************************
  // Helpers
  // ********************************************************
  function automatic logic len_ok(input logic [15:0] len);
    len_ok = (len != 16'h0000) && (len <= boot_loader_pkg::DESC_MAX_LEN);
  endfunction : len_ok

  // Highest set bit wins, so setup outranks ready
  function automatic logic [7:0] top_bit(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (v[i]) r = 8'(8'h01 << i);
    end
    top_bit = r;
  endfunction : top_bit

  // ********************************************************
  // Boot state
  // ********************************************************
  boot_loader_pkg::boot_state_t state_ff;
  boot_loader_pkg::boot_state_t nxt_state;
  logic [15:0] idx_ff;
  logic [2:0]  strap_ff;
  logic [7:0]  ifcfg_ff;
  logic [7:0]  pol_ff;
  logic [15:0] len_ff;
  logic [47:0] id_ff;
  logic        rd_done;
  logic        rd_nack;
  logic [7:0]  rd_data;

  eeprom_byte_reader u_reader (
    .i_clock    (I_CLOCK),
    .i_rstn     (I_RSTN),
    .i_start    (state_ff == boot_loader_pkg::B_READ),
    .i_two_addr (strap_ff == boot_loader_pkg::STRAP_TWO_BYTE),
    .i_strap    (strap_ff),
    .i_index    (idx_ff),
    .i_scl_in   (I_EEPROM_SCL_IN),
    .i_sda_in   (I_EEPROM_SDA_IN),
    .o_scl_oe   (O_EEPROM_SCL_OE),
    .o_sda_oe   (O_EEPROM_SDA_OE),
    .o_done     (rd_done),
    .o_nack     (rd_nack),
    .o_data     (rd_data)
  );

  // ********************************************************
  // Byte intake, shared by memory and master paths
  // ********************************************************
  // The master's byte k lands at memory index k+4, so one decoder serves both
  wire        in_master = state_ff == boot_loader_pkg::B_MASTER;
  wire        ee_done   = (state_ff == boot_loader_pkg::B_WAIT) & rd_done;
  wire        m_wr      = in_master & I_CMD_WRITE & (I_CMD_ADDR == boot_loader_pkg::MASTER_DESC_REG);
  wire [7:0]  in_byte   = in_master ? I_CMD_DATA : rd_data;
  wire        hdr_idx   = (idx_ff == boot_loader_pkg::IDX_HDR) | (idx_ff == boot_loader_pkg::IDX_DESC_FLAG);
  wire        hdr_bad   = hdr_idx & (rd_data != boot_loader_pkg::HDR_MAGIC);
  wire        len_bad   = (idx_ff == boot_loader_pkg::IDX_LEN_HI) & ~len_ok({in_byte, len_ff[7:0]});
  wire        ee_fail   = ee_done & (rd_nack | hdr_bad | len_bad);
  wire        in_take   = (ee_done & ~ee_fail) | (m_wr & ~len_bad);
  wire        is_pay    = in_take & (idx_ff >= boot_loader_pkg::IDX_PAYLOAD);
  wire [15:0] pay_off   = 16'(idx_ff - boot_loader_pkg::IDX_PAYLOAD);
  wire        pay_last  = is_pay & (16'(pay_off + 16'h0001) == len_ff);
  wire        is_dflt   = len_ff == boot_loader_pkg::DEFAULT_DESC_LEN;
  wire [5:0]  id_pos    = {pay_off[2:0], 3'h0};
  wire [15:0] nxt_idx   = (ee_fail | (m_wr & len_bad)) ? boot_loader_pkg::IDX_LEN_LO :
                          (in_take ? 16'(idx_ff + 16'h0001) : idx_ff);

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      boot_loader_pkg::B_STRAP:  nxt_state = boot_loader_pkg::B_READ;
      boot_loader_pkg::B_READ:   nxt_state = boot_loader_pkg::B_WAIT;
      boot_loader_pkg::B_WAIT: begin
        if (ee_fail) nxt_state = boot_loader_pkg::B_MASTER;
        else if (pay_last) nxt_state = boot_loader_pkg::B_ENUM;
        else if (in_take) nxt_state = boot_loader_pkg::B_READ;
      end
      boot_loader_pkg::B_MASTER: if (pay_last) nxt_state = boot_loader_pkg::B_ENUM;
      boot_loader_pkg::B_ENUM:   nxt_state = boot_loader_pkg::B_ENUM;
    endcase
  end

  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      state_ff <= boot_loader_pkg::B_STRAP;
      idx_ff   <= boot_loader_pkg::IDX_HDR;
      strap_ff <= boot_loader_pkg::STRAP_ONE_BYTE;
    end else begin
      state_ff <= nxt_state;
      idx_ff   <= nxt_idx;
      // Strap is caught on the first edge after release
      if (state_ff == boot_loader_pkg::B_STRAP) strap_ff <= I_EEPROM_ADDR_STRAP;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      ifcfg_ff <= boot_loader_pkg::IFCFG_RESET;
      pol_ff   <= boot_loader_pkg::POL_RESET;
      len_ff   <= 16'h0000;
      id_ff    <= boot_loader_pkg::ID_RESET;
    end else if (in_take) begin
      if (idx_ff == boot_loader_pkg::IDX_IFCFG) ifcfg_ff <= in_byte;
      if (idx_ff == boot_loader_pkg::IDX_POL) pol_ff <= in_byte;
      if (idx_ff == boot_loader_pkg::IDX_LEN_LO) len_ff[7:0] <= in_byte;
      if (idx_ff == boot_loader_pkg::IDX_LEN_HI) len_ff[15:8] <= in_byte;
      if (is_pay & is_dflt) id_ff[id_pos +: 8] <= in_byte;
    end
  end

  assign O_INTERFACE_CONFIG  = ifcfg_ff;
  assign O_FLAG_POLARITY     = pol_ff;
  assign O_DESC_LENGTH       = len_ff;
  assign O_VENDOR_ID         = id_ff[15:0];
  assign O_PRODUCT_ID        = id_ff[31:16];
  assign O_DEVICE_RELEASE_ID = id_ff[47:32];

  // ********************************************************
  // Descriptor stream and enumeration
  // ********************************************************
  // Descriptor bytes are handed out one by one; the store lives outside
  wire enum_on = state_ff == boot_loader_pkg::B_ENUM;

  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_DESC_WE        <= 1'b0;
      O_DESC_BYTE      <= 8'h00;
      O_DESC_ADDR      <= 9'h000;
      O_USB_CONNECT    <= 1'b0;
      O_DEFAULT_DESC   <= 1'b0;
      O_EP_IN_MASK     <= 4'h0;
      O_EP_MAX_PKT     <= 10'h000;
      O_EEPROM_SCL_OUT <= 1'b0;
      O_EEPROM_SDA_OUT <= 1'b0;
    end else begin
      O_DESC_WE      <= is_pay & ~is_dflt;
      O_DESC_BYTE    <= in_byte;
      O_DESC_ADDR    <= pay_off[8:0];
      O_USB_CONNECT  <= enum_on;
      O_DEFAULT_DESC <= enum_on & is_dflt;
      O_EP_IN_MASK   <= (enum_on & is_dflt) ? boot_loader_pkg::EP_IN_DEFAULT : 4'h0;
      O_EP_MAX_PKT   <= (enum_on & is_dflt) ? (I_HIGH_SPEED ? boot_loader_pkg::PKT_HS :
                                               boot_loader_pkg::PKT_FS) : 10'h000;
    end
  end

  // ********************************************************
  // Interrupt sources and presenter
  // ********************************************************
  logic [7:0] pend_ff;
  logic [7:0] cur_ff;
  logic [7:0] rdata_ff;
  logic       act_ff;
  logic       is_data_ff;
  logic       rreq_ff;
  logic       rdv_ff;
  logic       rd_q_ff;
  logic [7:0] ev_raw;

  // Ready fires only when no valid stored descriptor is found
  assign ev_raw[boot_loader_pkg::IRQ_SETUP_BIT]     = I_SETUP_EVT;
  assign ev_raw[boot_loader_pkg::IRQ_CTRL_BUF_BIT]  = I_CTRL_BUFFER_AVAIL_EVT;
  assign ev_raw[boot_loader_pkg::IRQ_OUT_FIFO_BIT]  = I_OUT_FIFO_CHANGE_EVT;
  assign ev_raw[4:3]                                = 2'h0;
  assign ev_raw[boot_loader_pkg::IRQ_ENUM_DONE_BIT] = I_SET_CONFIG_EVT;
  assign ev_raw[boot_loader_pkg::IRQ_USB_IDLE_BIT]  = I_USB_IDLE_CHANGE_EVT;
  assign ev_raw[boot_loader_pkg::IRQ_READY_BIT]     = ee_fail;

  wire [7:0] ev        = ev_raw & I_IRQ_ENABLE_MASK;
  wire       rd_lvl    = I_SLAVE_READ_STROBE & I_SLAVE_OUTPUT_ENABLE;
  wire       take      = rd_lvl & ~rd_q_ff & act_ff;
  wire [7:0] clr       = (take & ~is_data_ff) ? cur_ff : 8'h00;
  wire [7:0] nxt_pend  = (pend_ff & ~clr) | ev;
  wire       can_data  = ~act_ff & rreq_ff & rdv_ff;
  wire       can_stat  = ~act_ff & ~rreq_ff & (pend_ff != 8'h00);
  wire       data_done = take & is_data_ff;
  wire       nxt_act   = (act_ff & ~take) | can_data | can_stat;

  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      pend_ff    <= 8'h00;
      act_ff     <= 1'b0;
      cur_ff     <= 8'h00;
      is_data_ff <= 1'b0;
      rd_q_ff    <= 1'b0;
      O_IRQ_N    <= 1'b1;
    end else begin
      pend_ff <= nxt_pend;
      act_ff  <= nxt_act;
      rd_q_ff <= rd_lvl;
      O_IRQ_N <= ~nxt_act;
      if (can_data | can_stat) begin
        cur_ff     <= can_data ? 8'h00 : top_bit(pend_ff);
        is_data_ff <= can_data;
      end
    end
  end

  // A new request in the cycle its predecessor is read wins
  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rreq_ff  <= 1'b0;
      rdv_ff   <= 1'b0;
      rdata_ff <= 8'h00;
    end else begin
      rreq_ff <= I_REG_READ_REQ | (rreq_ff & ~data_done);
      rdv_ff  <= (rdv_ff & ~data_done & ~I_REG_READ_REQ) | (rreq_ff & I_REG_READ_VALID);
      if (rreq_ff & I_REG_READ_VALID) rdata_ff <= I_REG_READ_DATA;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_HOST_DATA_BUS <= 8'h00;
      O_HOST_DATA_OE  <= 1'b0;
    end else begin
      if (take) O_HOST_DATA_BUS <= is_data_ff ? rdata_ff : cur_ff;
      O_HOST_DATA_OE <= rd_lvl & (O_HOST_DATA_OE | take);
    end
  end

endmodule : usb_boot_loader_and_irq

// [boot_irq_checker.sv]
/* Port-level assertions for the loader and interrupt presenter.
   Bound to the top module; sees only its ports. */
`timescale 1ns/1ns
module boot_irq_checker (
  input wire logic       I_CLOCK,
  input wire logic       I_RSTN,
  input wire logic       I_SLAVE_READ_STROBE,
  input wire logic       I_SLAVE_OUTPUT_ENABLE,
  input wire logic       I_REG_READ_REQ,
  input wire logic       I_REG_READ_VALID,
  input wire logic       I_HIGH_SPEED,
  input wire logic       O_IRQ_N,
  input wire logic       O_HOST_DATA_OE,
  input wire logic [7:0] O_HOST_DATA_BUS,
  input wire logic       O_DEFAULT_DESC,
  input wire logic [3:0] O_EP_IN_MASK,
  input wire logic [9:0] O_EP_MAX_PKT,
  input wire logic       O_USB_CONNECT
);
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (!I_RSTN);
  logic rd_ff, pend_ff, got_ff;
  wire  rd = I_SLAVE_READ_STROBE & I_SLAVE_OUTPUT_ENABLE;
  wire  rd_rise = rd & ~rd_ff;
  // Tracks a register read so status reads are not mistaken for its data
  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      {rd_ff, pend_ff, got_ff} <= 3'h0;
    end else begin
      rd_ff <= rd;
      pend_ff <= I_REG_READ_REQ | (pend_ff & ~(rd_rise & got_ff));
      got_ff <= pend_ff & (got_ff | I_REG_READ_VALID) & ~(rd_rise & got_ff);
    end
  end
  read_clear_a: assert property (rd_rise && !O_IRQ_N |=> O_IRQ_N)
    else $error("interrupt not released by read");
  status_onehot_a: assert property (rd_rise && !O_IRQ_N && !got_ff |=> O_HOST_DATA_OE && $onehot(O_HOST_DATA_BUS))
    else $error("status byte not one bit");
  idle_read_a: assert property (rd_rise && O_IRQ_N |=> !O_HOST_DATA_OE)
    else $error("bus driven without interrupt");
  oe_read_a: assert property (O_HOST_DATA_OE |-> rd_ff)
    else $error("bus driven outside read");
  held_back_a: assert property (pend_ff && !got_ff && O_IRQ_N && !I_REG_READ_VALID |=> O_IRQ_N)
    else $error("interrupt during register read");
  data_irq_a: assert property ($rose(got_ff) && O_IRQ_N |-> ##[1:3] !O_IRQ_N)
    else $error("no interrupt for read data");
  sticky_conn_a: assert property (O_USB_CONNECT |=> O_USB_CONNECT)
    else $error("connect dropped");
  ep_default_a: assert property (O_DEFAULT_DESC ##1 $stable(I_HIGH_SPEED)
    |-> O_EP_IN_MASK == 4'hC && O_EP_MAX_PKT == (I_HIGH_SPEED ? 10'h200 : 10'h040))
    else $error("default endpoints wrong");
  cover property (rd_rise && !O_IRQ_N);
  cover property ($rose(got_ff));
  cover property ($rose(O_USB_CONNECT));
endmodule : boot_irq_checker

// [boot_eeprom.sv]
/* Behavioural boot memory on the two-wire bus, one index byte.
   Assumes pull-ups; o_pull high pulls the data line low. */
`timescale 1ns/1ns
module boot_eeprom (
  input  wire logic i_scl,
  input  wire logic i_sda,
  input  wire logic i_present,
  output logic      o_pull
);
  logic [7:0] mem [12] = '{8'hC4, 8'hA5, 8'h3C, 8'hC4, 8'h06, 8'h00, 8'h21, 8'h43, 8'h65, 8'h87, 8'hA9, 8'hCB};
  logic [7:0] sh, idx;
  logic       rd, out;
  int         b, nb;
  initial o_pull = 0;
  always @(negedge i_sda) if (i_scl) begin
    b = 0;
    nb = 0;
    out = 0;
  end
  always @(posedge i_scl) begin
    b = b + 1;
    sh = {sh[6:0], i_sda};
  end
  always @(negedge i_scl) begin
    if (b == 8 && !out) begin
      if (nb == 0) rd = sh[0];
      if (nb == 1) idx = sh;
      o_pull = i_present && (nb > 0 || sh[7:4] == 4'hA);
      nb = nb + 1;
    end else if (b == 9) begin
      b = 0;
      out = rd && o_pull;
      o_pull = 0;
    end
    // Master sends its own NACK after bit 0, so the line is let go
    if (out) o_pull = (b < 8) ? ~mem[idx][7-b] : 1'b0;
  end
endmodule : boot_eeprom

// [tb_top.sv]
/* Top testbench: boot without and with memory, master writes, events,
   status and register reads. Assumes the memory model and checker. */
`timescale 1ns/1ns
module tb_top;
  logic I_CLOCK = 0, I_RSTN = 0, I_HIGH_SPEED = 1, I_CMD_WRITE = 0, I_REG_READ_REQ = 0, I_REG_READ_VALID = 0;
  logic rdl = 0, prs = 0, pull, O_EEPROM_SCL_OUT, O_EEPROM_SCL_OE, O_EEPROM_SDA_OUT, O_EEPROM_SDA_OE;
  logic O_DESC_WE, O_DEFAULT_DESC, O_USB_CONNECT, O_IRQ_N, O_HOST_DATA_OE;
  logic [2:0] I_EEPROM_ADDR_STRAP = 3'h0;
  logic [4:0] evs = 5'h0;
  logic [5:0] I_CMD_ADDR = 6'h30;
  logic [7:0] I_CMD_DATA = 0, I_IRQ_ENABLE_MASK = 8'hE7, I_REG_READ_DATA = 0;
  logic [7:0] O_INTERFACE_CONFIG, O_FLAG_POLARITY, O_DESC_BYTE, O_HOST_DATA_BUS;
  logic [15:0] O_VENDOR_ID, O_PRODUCT_ID, O_DEVICE_RELEASE_ID, O_DESC_LENGTH;
  logic [8:0] O_DESC_ADDR;
  logic [3:0] O_EP_IN_MASK;
  logic [9:0] O_EP_MAX_PKT;
  logic [7:0] dq [8] = '{8'h06, 8'h00, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16};
  logic [7:0] dz [6] = '{8'hF5, 8'h01, 8'h02, 8'h00, 8'hAA, 8'hBB};
  logic [7:0] pri [5] = '{8'h80, 8'h40, 8'h20, 8'h04, 8'h02};
  wire I_SETUP_EVT = evs[4], I_CTRL_BUFFER_AVAIL_EVT = evs[3], I_OUT_FIFO_CHANGE_EVT = evs[2];
  wire I_SET_CONFIG_EVT = evs[1], I_USB_IDLE_CHANGE_EVT = evs[0];
  wire I_SLAVE_READ_STROBE = rdl, I_SLAVE_OUTPUT_ENABLE = rdl;
  wire I_EEPROM_SCL_IN = ~O_EEPROM_SCL_OE;
  wire I_EEPROM_SDA_IN = ~(O_EEPROM_SDA_OE | pull);
  int error_cnt = 0, checks = 0, cyc = 0;
  always #50 I_CLOCK = ~I_CLOCK;
  usb_boot_loader_and_irq DUT (.*);
  boot_eeprom MEM (.i_scl(I_EEPROM_SCL_IN), .i_sda(I_EEPROM_SDA_IN), .i_present(prs), .o_pull(pull));
  task end_sim();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  // A full memory boot takes about 50000 cycles
  always @(posedge I_CLOCK) if (++cyc == 80000) begin
    error_cnt++;
    end_sim();
  end
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task step(input int n);
    repeat (n) @(negedge I_CLOCK);
  endtask : step
  task ev(input logic [4:0] v);
    step(1);
    evs = v;
    step(1);
    evs = 5'h0;
  endtask : ev
  task wirq();
    while (O_IRQ_N !== 1'b0) step(1);
  endtask : wirq
  task rd_stat(input logic [7:0] e, input logic oe);
    step(1);
    rdl = 1;
    step(2);
    chk("host_oe", oe, O_HOST_DATA_OE);
    if (oe) chk("host_bus", e, O_HOST_DATA_BUS);
    rdl = 0;
  endtask : rd_stat
  task wr(input logic [7:0] d);
    step(1);
    I_CMD_DATA = d;
    I_CMD_WRITE = 1;
    step(1);
    I_CMD_WRITE = 0;
  endtask : wr
  initial begin
    step(16);
    I_RSTN = 1;
    wirq();
    chk("connect", 0, O_USB_CONNECT);
    rd_stat(8'h01, 1);
    foreach (dq[i]) wr(dq[i]);
    step(3);
    chk("connect", 1, O_USB_CONNECT);
    chk("default", 1, O_DEFAULT_DESC);
    chk("vid", 16'h1211, O_VENDOR_ID);
    chk("pid", 16'h1413, O_PRODUCT_ID);
    chk("rel", 16'h1615, O_DEVICE_RELEASE_ID);
    chk("ep_in", 4'hC, O_EP_IN_MASK);
    chk("pkt", 10'h200, O_EP_MAX_PKT);
    I_HIGH_SPEED = 0;
    step(2);
    chk("pkt", 10'h040, O_EP_MAX_PKT);
    ev(5'h1F);
    foreach (pri[i]) begin
      wirq();
      rd_stat(pri[i], 1);
    end
    rd_stat(8'h00, 0);
    I_IRQ_ENABLE_MASK = 8'h00;
    ev(5'h10);
    step(4);
    chk("irq_n", 1, O_IRQ_N);
    I_IRQ_ENABLE_MASK = 8'hE7;
    I_REG_READ_REQ = 1;
    step(1);
    I_REG_READ_REQ = 0;
    ev(5'h02);
    step(4);
    chk("irq_n", 1, O_IRQ_N);
    I_REG_READ_DATA = 8'h5A;
    I_REG_READ_VALID = 1;
    step(1);
    I_REG_READ_VALID = 0;
    wirq();
    rd_stat(8'h5A, 1);
    wirq();
    rd_stat(8'h04, 1);
    prs = 1;
    I_RSTN = 0;
    step(16);
    I_RSTN = 1;
    while (O_USB_CONNECT !== 1'b1) step(1);
    chk("cfg", 16'hA53C, {O_INTERFACE_CONFIG, O_FLAG_POLARITY});
    chk("len", 16'h0006, O_DESC_LENGTH);
    chk("vid", 16'h4321, O_VENDOR_ID);
    chk("pid", 16'h8765, O_PRODUCT_ID);
    chk("rel", 16'hCBA9, O_DEVICE_RELEASE_ID);
    chk("irq_n", 1, O_IRQ_N);
    ev(5'h02);
    wirq();
    rd_stat(8'h04, 1);
    prs = 0;
    I_RSTN = 0;
    step(16);
    I_RSTN = 1;
    wirq();
    foreach (dz[i]) begin
      wr(dz[i]);
      if (i > 3) chk("desc", {1'b1, 7'(i - 4), dz[i]}, {O_DESC_WE, O_DESC_ADDR[6:0], O_DESC_BYTE});
    end
    step(1);
    chk("connect", 1, O_USB_CONNECT);
    chk("len", 16'h0002, O_DESC_LENGTH);
    chk("default", 0, O_DEFAULT_DESC);
    end_sim();
  end
endmodule : tb_top
bind usb_boot_loader_and_irq boot_irq_checker CHK (.*);
